// file: rtl/serial_drive_telegram_framer.sv
`timescale 1ns/10ps
// Overview of operation
// RULE1: Every element on the line lasts exactly eleven bit times.
// RULE2: Element is start bit, eight data bits LSB first, even parity, stop bit.
// RULE3: An idle delay always separates two telegrams on the bus.
// RULE4: First byte is start character 02 hex; receiver starts frame on it.
// RULE5: Length byte equals user data bytes plus address byte plus checksum byte.
// RULE6: Address bits 0-4 must match own address before a telegram is taken.
// RULE7: Master only uses addresses 1 to 30.
// RULE8: Address bit 7 marks a nonstandard user data structure.
// RULE9: Own telegram with address bit 6 set is echoed back unchanged.
// RULE10: Address bit 5 broadcast is unsupported; such telegrams are ignored.
// RULE11: Last byte is XOR of all prior bytes; receiver checks it.
// RULE12: Bad checksum, bad length or foreign address: drop without reply.
// RULE13: User data is parameter channel followed by process data words.
// RULE14: Channel length setting 0 means no parameter channel words.
// RULE15: Channel length setting 3 means three fixed channel words.
// RULE16: Channel length setting 4 means always four channel words.
// RULE17: Channel length setting 127 means length varies per telegram.
// RULE18: Process data holds 0 to 8 configured 16-bit words.
// RULE19: Words one and two carry number, index, job; value follows.
// RULE20: Unused value words are sent as zero by the sender.
// RULE21: Bit 11 of the first channel word is always sent zero. Mirror echoes send it as received.
// RULE22: Word 1 is job and number, word 2 page and subindex.
// RULE23: Request and response identifiers sit in word 1 bits 15..12.
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,             // system clock
  input wire logic resetn,              // async reset, active low
  input wire logic [WIDTH-1:0] inData,  // write data
  input wire logic inValid,             // write request
  output logic inReady,                 // space available
  output logic [WIDTH-1:0] outData,     // head of queue
  output logic outValid,                // queue not empty
  input wire logic outReady             // consumer takes head
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic room;
  } fifo_s;
  fifo_s st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // Registered so the ready seen outside comes straight from a flip-flop
  assign inReady = st.room;
  assign outValid = st.wrPtr != st.rdPtr;
  assign outData = mem[st.rdPtr[AW-1:0]];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wrPtr = st.wrPtr + 1'b1;
    end
    if (pop)
    begin
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
    next_st.room = (next_st.wrPtr - next_st.rdPtr) != (AW+1)'(DEPTH);
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.room <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[st.wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule : byte_fifo

module serial_drive_telegram_framer #(
  parameter int GAP_CYCLES = telegram_pkg::GAP_CYCLES
) (
  input wire logic sys_clk,                     // 25 MHz system clock
  input wire logic resetn,                      // async reset, active low
  input wire logic rxPin,                       // RS485 receive line
  output logic txPin,                           // RS485 transmit line
  output logic txEnable,                        // RS485 driver enable
  input wire telegram_pkg::telegram_cfg_s cfg,  // address and layout settings
  output logic [7:0] rxData,                    // accepted user data byte
  output logic rxDataValid,                     // rxData strobe
  output logic rxDataLast,                      // last user data byte
  output logic frameGood,                       // telegram accepted, reply due
  output logic frameSpecial,                    // address bit 7 of accepted frame
  output telegram_pkg::param_fields_s params,   // decoded channel head
  input wire logic replyGo,                     // start reply of replyLength bytes
  input wire logic replyDrop,                   // give up reply, rearm receiver
  input wire logic [7:0] replyLength,           // reply user data byte count
  input wire logic [7:0] replyData,             // reply byte into queue
  input wire logic replyValid,                  // replyData strobe
  output logic replyReady                       // queue has space
);
  typedef enum logic [2:0] {
    S_HUNT, S_LEN, S_BODY, S_CHECK, S_DELIVER, S_WAIT, S_GAP, S_TX
  } state_e;

  typedef struct packed {
    state_e state;
    logic rxMeta;
    logic rxSyncd;
    logic rxBusy;
    logic [telegram_pkg::BAUD_W-1:0] rxBaud;
    logic [3:0] rxBitIdx;
    logic [9:0] rxShift;
    logic txBusy;
    logic [telegram_pkg::BAUD_W-1:0] txBaud;
    logic [3:0] txBitIdx;
    logic [10:0] txShift;
    logic txPin;
    logic txEnable;
    logic [7:0] idx;
    logic [7:0] frame_length_byte;
    logic [7:0] sum;
    logic [7:0] adr;
    logic [7:0] txSum;
    logic mirror;
    logic [telegram_pkg::GAP_W-1:0] gapCnt;
    logic [7:0] rxData;
    logic rxDataValid;
    logic rxDataLast;
    logic frameGood;
    logic frameSpecial;
    telegram_pkg::param_fields_s params;
  } framer_s;

  framer_s st, next_st;
  logic [7:0] buffer [256];
  logic [7:0] bufRd, rxByte, txByte;
  logic memWe, rxStrobe, rxOk, txLoad, fifoValid, fifoPop;
  logic [7:0] fifoData;

  function automatic logic lengthOk(input logic [7:0] frame_length_byte, input logic [6:0] pcl,
                                    input logic [3:0] process_data_area);
    logic [8:0] user, pzdBytes;
    user = {1'b0, frame_length_byte} - 9'(telegram_pkg::MIN_LENGTH);
    pzdBytes = {4'h0, process_data_area, 1'b0};
    lengthOk = 1'b0;
    if (process_data_area <= telegram_pkg::PZD_MAX && frame_length_byte >= telegram_pkg::MIN_LENGTH)
    begin
      case (pcl)
        telegram_pkg::PCL_NONE: lengthOk = user == pzdBytes; // [RULE14] [RULE18]
        telegram_pkg::PCL_THREE: lengthOk = user == pzdBytes + 9'd6; // [RULE15]
        telegram_pkg::PCL_FOUR: lengthOk = user == pzdBytes + 9'd8; // [RULE16]
        telegram_pkg::PCL_VARIABLE: lengthOk = user >= pzdBytes && !user[0]; // [RULE17]
        default: lengthOk = 1'b0;
      endcase
    end
  endfunction : lengthOk

  byte_fifo #(
    .WIDTH(telegram_pkg::FIFO_WIDTH),
    .DEPTH(telegram_pkg::FIFO_DEPTH)
  ) replyQueue (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .inData(replyData),
    .inValid(replyValid),
    .inReady(replyReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  assign bufRd = buffer[st.idx];
  assign txPin = st.txPin;
  assign txEnable = st.txEnable;
  assign rxData = st.rxData;
  assign rxDataValid = st.rxDataValid;
  assign rxDataLast = st.rxDataLast;
  assign frameGood = st.frameGood;
  assign frameSpecial = st.frameSpecial;
  assign params = st.params;

  always_comb
  begin
    logic addrHit, sumOk, layoutOk;
    addrHit = st.adr[4:0] == cfg.address; // [RULE6]
    sumOk = st.sum == 8'h00; // [RULE11]
    layoutOk = st.adr[telegram_pkg::ADR_SPECIAL] || st.adr[telegram_pkg::ADR_MIRROR] ||
               lengthOk(st.frame_length_byte, cfg.parameter_channel_length_setting,
                        cfg.process_word_count_setting); // [RULE8] [RULE13]
    next_st = st;
    next_st.rxMeta = rxPin;
    next_st.rxSyncd = st.rxMeta;
    next_st.rxDataValid = 1'b0;
    next_st.rxDataLast = 1'b0;
    next_st.frameGood = 1'b0;
    rxStrobe = 1'b0;
    rxOk = 1'b0;
    rxByte = next_st.rxShift[7:0];
    memWe = 1'b0;
    txLoad = 1'b0;
    txByte = 8'h00;
    fifoPop = 1'b0;
    // Receive element engine, samples each bit at its centre
    if (!st.rxBusy)
    begin
      if (!st.rxSyncd)
      begin
        next_st.rxBusy = 1'b1;
        next_st.rxBaud = telegram_pkg::HALF_RELOAD;
        next_st.rxBitIdx = 4'h0;
      end
    end
    else if (st.rxBaud != '0)
    begin
      next_st.rxBaud = st.rxBaud - 1'b1;
    end
    else
    begin
      next_st.rxBaud = telegram_pkg::BIT_RELOAD;
      if (st.rxBitIdx == 4'h0 && st.rxSyncd)
      begin
        next_st.rxBusy = 1'b0; // Glitch, not a start bit
      end
      else
      begin
        if (st.rxBitIdx != 4'h0)
        begin
          next_st.rxShift = {st.rxSyncd, st.rxShift[9:1]};
        end
        next_st.rxBitIdx = st.rxBitIdx + 1'b1;
        if (st.rxBitIdx == telegram_pkg::LAST_BIT) // [RULE1]
        begin
          next_st.rxBusy = 1'b0;
          rxStrobe = 1'b1;
        end
      end
    end
    rxByte = next_st.rxShift[7:0];
    rxOk = next_st.rxShift[9] && (next_st.rxShift[8] == ^rxByte); // [RULE2]
    // Transmit element engine
    if (st.txBusy)
    begin
      if (st.txBaud != '0)
      begin
        next_st.txBaud = st.txBaud - 1'b1;
      end
      else if (st.txBitIdx == telegram_pkg::LAST_BIT) // [RULE1]
      begin
        next_st.txBusy = 1'b0;
      end
      else
      begin
        next_st.txBaud = telegram_pkg::BIT_RELOAD;
        next_st.txBitIdx = st.txBitIdx + 1'b1;
        next_st.txShift = {1'b1, st.txShift[10:1]};
      end
    end
    case (st.state)
      S_HUNT:
      begin
        next_st.idx = 8'h00;
        if (rxStrobe && rxOk && rxByte == telegram_pkg::START_OF_FRAME_CHAR) // [RULE4]
        begin
          memWe = 1'b1;
          next_st.sum = rxByte;
          next_st.idx = telegram_pkg::IDX_LEN;
          next_st.state = S_LEN;
        end
      end
      S_LEN, S_BODY:
      begin
        if (rxStrobe)
        begin
          memWe = rxOk;
          next_st.sum = st.sum ^ rxByte; // [RULE11]
          next_st.idx = st.idx + 1'b1;
          if (st.state == S_LEN)
          begin
            next_st.frame_length_byte = rxByte; // [RULE5]
            next_st.state = rxByte < telegram_pkg::MIN_LENGTH ? S_HUNT : S_BODY; // [RULE12]
          end
          else if (st.idx == st.frame_length_byte + 1'b1)
          begin
            next_st.state = S_CHECK;
          end
          if (st.idx == telegram_pkg::IDX_ADR)
          begin
            next_st.adr = rxByte;
          end
          if (!rxOk)
          begin
            next_st.state = S_HUNT; // [RULE12]
          end
        end
      end
      S_CHECK:
      begin
        next_st.state = S_HUNT; // [RULE12]
        next_st.idx = telegram_pkg::IDX_WORD1_HI;
        next_st.mirror = 1'b0;
        next_st.gapCnt = '0;
        if (addrHit && sumOk && layoutOk && !st.adr[telegram_pkg::ADR_BROADCAST]) // [RULE10]
        begin
          if (st.adr[telegram_pkg::ADR_MIRROR]) // [RULE9]
          begin
            next_st.mirror = 1'b1;
            next_st.state = S_GAP;
          end
          else
          begin
            next_st.frameSpecial = st.adr[telegram_pkg::ADR_SPECIAL]; // [RULE8]
            next_st.state = S_DELIVER;
          end
        end
      end
      S_DELIVER:
      begin
        if (st.idx > st.frame_length_byte)
        begin
          next_st.frameGood = 1'b1;
          next_st.state = S_WAIT;
        end
        else
        begin
          next_st.rxData = bufRd;
          next_st.rxDataValid = 1'b1;
          next_st.rxDataLast = st.idx == st.frame_length_byte;
          next_st.idx = st.idx + 1'b1;
          if (cfg.parameter_channel_length_setting != telegram_pkg::PCL_NONE)
          begin
            case (st.idx) // [RULE19] [RULE22] [RULE23]
              telegram_pkg::IDX_WORD1_HI:
              begin
                next_st.params.job_identifier = bufRd[7:4];
                next_st.params.parameter_number[10:8] = bufRd[2:0];
              end
              telegram_pkg::IDX_WORD1_LO: next_st.params.parameter_number[7:0] = bufRd;
              telegram_pkg::IDX_WORD2_HI: next_st.params.pageIndex = bufRd;
              telegram_pkg::IDX_WORD2_LO: next_st.params.subIndex = bufRd;
              default: next_st.params = st.params;
            endcase
          end
        end
      end
      S_WAIT:
      begin
        next_st.gapCnt = '0;
        if (replyGo)
        begin
          next_st.frame_length_byte = replyLength + telegram_pkg::MIN_LENGTH; // [RULE5]
          next_st.state = S_GAP;
        end
        else if (replyDrop)
        begin
          next_st.state = S_HUNT;
        end
      end
      S_GAP:
      begin
        next_st.gapCnt = st.gapCnt + 1'b1;
        if (st.gapCnt == telegram_pkg::GAP_W'(GAP_CYCLES - 1)) // [RULE3]
        begin
          next_st.idx = 8'h00;
          next_st.txSum = 8'h00;
          next_st.txEnable = 1'b1;
          next_st.state = S_TX;
        end
      end
      S_TX:
      begin
        if (!st.txBusy)
        begin
          txLoad = 1'b1;
          if (st.idx == st.frame_length_byte + telegram_pkg::MIN_LENGTH)
          begin
            txLoad = 1'b0;
            next_st.txEnable = 1'b0;
            next_st.state = S_HUNT;
          end
          else if (st.mirror)
          begin
            txByte = bufRd; // [RULE9]
          end
          else if (st.idx == 8'h00)
          begin
            txByte = telegram_pkg::START_OF_FRAME_CHAR; // [RULE4]
          end
          else if (st.idx == telegram_pkg::IDX_LEN)
          begin
            txByte = st.frame_length_byte; // [RULE5]
          end
          else if (st.idx == telegram_pkg::IDX_ADR)
          begin
            txByte = {3'b000, cfg.address}; // [RULE6] [RULE10]
          end
          else if (st.idx == st.frame_length_byte + 1'b1)
          begin
            txByte = st.txSum; // [RULE11]
          end
          else
          begin
            txLoad = fifoValid; // Stalls mid-frame if the user falls behind
            fifoPop = fifoValid;
            txByte = fifoData; // Zero fill of unused value words is the caller's [RULE20]
            if (st.idx == telegram_pkg::IDX_WORD1_HI &&
                cfg.parameter_channel_length_setting != telegram_pkg::PCL_NONE)
            begin
              txByte = fifoData & telegram_pkg::RESERVED_MASK; // [RULE21]
            end
          end
          if (txLoad)
          begin
            next_st.txShift = {1'b1, ^txByte, txByte, 1'b0}; // [RULE2]
            next_st.txBusy = 1'b1;
            next_st.txBaud = telegram_pkg::BIT_RELOAD;
            next_st.txBitIdx = 4'h0;
            next_st.txSum = st.txSum ^ txByte;
            next_st.idx = st.idx + 1'b1;
          end
        end
      end
      default: next_st.state = S_HUNT;
    endcase
    next_st.txPin = next_st.txBusy ? next_st.txShift[0] : 1'b1;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.state <= S_HUNT;
      st.rxMeta <= 1'b1;
      st.rxSyncd <= 1'b1;
      st.txPin <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (memWe)
    begin
      buffer[st.idx] <= rxByte;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_tx_idle_high: assert property (!st.txBusy |-> st.txPin) // [RULE2]
    else $error("line not idle high between elements");
  chk_element_start: assert property ( // [RULE1]
    txLoad |=> st.txBusy && !st.txPin && st.txBitIdx == 4'h0)
    else $error("element does not begin with a low start bit");
  chk_first_byte_stx: assert property ( // [RULE4]
    txLoad && st.idx == 8'h00 && !st.mirror |-> txByte == telegram_pkg::START_OF_FRAME_CHAR)
    else $error("telegram does not open with start character");
  chk_gap_before_tx: assert property ( // [RULE3]
    st.state == S_TX && $past(st.state) == S_GAP |->
    $past(st.gapCnt) == telegram_pkg::GAP_W'(GAP_CYCLES - 1))
    else $error("reply started without full idle delay");
  chk_bad_sum_drop: assert property ( // [RULE11]
    st.state == S_CHECK && st.sum != 8'h00 |=> st.state == S_HUNT ##1 !st.frameGood [*4])
    else $error("telegram with bad checksum was taken");
  chk_foreign_addr: assert property ( // [RULE6]
    st.state == S_CHECK && st.adr[4:0] != cfg.address |=> st.state == S_HUNT && !st.txEnable)
    else $error("telegram for another slave was taken");
  chk_broadcast_drop: assert property ( // [RULE10]
    st.state == S_CHECK && st.adr[5] |=> st.state == S_HUNT)
    else $error("broadcast telegram was taken");
  chk_mirror_path: assert property ( // [RULE9]
    st.state == S_CHECK && st.adr[6] && st.adr[4:0] == cfg.address && st.sum == 8'h00 &&
    !st.adr[5] |=> st.state == S_GAP && st.mirror)
    else $error("mirror telegram not echoed");
  chk_reply_length: assert property ( // [RULE5]
    txLoad && !st.mirror && st.idx == 8'h01 |-> txByte == st.frame_length_byte && $past(st.frame_length_byte) == st.frame_length_byte)
    else $error("length byte of reply is wrong");
  chk_reserved_bit: assert property ( // [RULE21]
    txLoad && !st.mirror && st.idx == 8'h03 &&
    cfg.parameter_channel_length_setting != 7'h00 |-> !txByte[3])
    else $error("reserved bit of first channel word sent as one");

  cov_mirror_reply: cover property (
    st.state == S_TX && st.mirror ##1 st.state == S_HUNT && !st.txEnable);
  cov_normal_reply: cover property (st.frameGood ##[1:20] st.state == S_GAP);
  cov_bad_frame: cover property (st.state == S_CHECK && st.sum != 8'h00);
endmodule : serial_drive_telegram_framer

// file: include/telegram_pkg.sv
package telegram_pkg;

  localparam int CLK_HZ = 25_000_000;
  // Fastest listed rate; keeps a telegram to a few thousand clocks
  localparam int BAUD_RATE = 187_500;
  // Bit period rounded down; error stays far below the UART sampling margin
  localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int ELEMENT_BITS = 11;
  localparam int GAP_ELEMENTS = 2;
  localparam int GAP_CYCLES = GAP_ELEMENTS * ELEMENT_BITS * BIT_CYCLES;
  localparam int GAP_W = 17;
  localparam int BAUD_W = 12;

  localparam logic [11:0] BIT_RELOAD = 12'(BIT_CYCLES - 1);
  localparam logic [11:0] HALF_RELOAD = 12'(HALF_BIT_CYCLES - 1);
  localparam logic [3:0] LAST_BIT = 4'(ELEMENT_BITS - 1);

  localparam logic [7:0] START_OF_FRAME_CHAR = 8'h02;
  localparam logic [7:0] MIN_LENGTH = 8'h02;
  localparam logic [7:0] IDX_LEN = 8'h01;
  localparam logic [7:0] IDX_ADR = 8'h02;
  localparam logic [7:0] IDX_WORD1_HI = 8'h03;
  localparam logic [7:0] IDX_WORD1_LO = 8'h04;
  localparam logic [7:0] IDX_WORD2_HI = 8'h05;
  localparam logic [7:0] IDX_WORD2_LO = 8'h06;
  localparam logic [7:0] RESERVED_MASK = 8'hF7;

  localparam int ADR_SPECIAL = 7;
  localparam int ADR_MIRROR = 6;
  localparam int ADR_BROADCAST = 5;

  localparam logic [6:0] PCL_NONE = 7'h00;
  localparam logic [6:0] PCL_THREE = 7'h03;
  localparam logic [6:0] PCL_FOUR = 7'h04;
  localparam logic [6:0] PCL_VARIABLE = 7'h7F;
  localparam logic [3:0] PZD_MAX = 4'h8;

  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;

  typedef struct packed {
    logic [4:0] address;                // own bus address
    logic [3:0] process_word_count_setting;
    logic [6:0] parameter_channel_length_setting;
  } telegram_cfg_s;

  typedef struct packed {
    logic [3:0] job_identifier;
    logic [10:0] parameter_number;
    logic [7:0] pageIndex;
    logic [7:0] subIndex;
  } param_fields_s;

endpackage : telegram_pkg

// file: test/telegram_master_model.sv
`timescale 1ns/10ps
module telegram_master_model (
  input wire logic sys_clk,  // bench clock
  input wire logic txPin,    // device transmit line
  input wire logic txEnable, // device driver enable
  output logic lineOut       // master drive into device
);
  localparam int BIT = telegram_pkg::BIT_CYCLES;
  logic [7:0] got[$];
  logic [9:0] sh;
  int badElems = 0;

  initial lineOut = 1'h1;

  // Appends the checksum; the idle tail keeps telegrams from touching
  task automatic send(input logic [7:0] body[$]);
    logic [7:0] q[$];
    logic [7:0] x;
    logic [10:0] el;
    q = body;
    x = 8'h00;
    foreach (body[k]) x ^= body[k];
    q.push_back(x);
    foreach (q[k])
    begin
      el = {1'h1, ^q[k], q[k], 1'h0};
      for (int i = 0; i < 11; i++)
      begin
        lineOut = el[i];
        repeat (BIT) @(negedge sys_clk);
      end
    end
    lineOut = 1'h1;
    repeat (4 * BIT) @(negedge sys_clk);
  endtask : send

  // Samples mid-bit on the falling edge, away from the device's updates
  initial forever
  begin
    @(negedge sys_clk);
    if (txEnable === 1'h1 && txPin === 1'h0)
    begin
      repeat (BIT / 2) @(negedge sys_clk);
      for (int i = 0; i < 10; i++)
      begin
        repeat (BIT) @(negedge sys_clk);
        sh[i] = txPin;
      end
      if (^sh[8:0] !== 1'h0 || sh[9] !== 1'h1)
        badElems++;
      got.push_back(sh[7:0]);
    end
  end
endmodule : telegram_master_model

// file: test/serial_drive_telegram_framer_bench.sv
`timescale 1ns/10ps
module serial_drive_telegram_framer_bench;
  localparam int BIT = telegram_pkg::BIT_CYCLES;
  localparam int GAP = 50;
  logic sys_clk;
  logic resetn;
  logic rxPin;
  logic txPin;
  logic txEnable;
  telegram_pkg::telegram_cfg_s cfg;
  logic [7:0] rxData;
  logic rxDataValid;
  logic rxDataLast;
  logic frameGood;
  logic frameSpecial;
  telegram_pkg::param_fields_s params;
  logic replyGo;
  logic replyDrop;
  logic [7:0] replyLength;
  logic [7:0] replyData;
  logic replyValid;
  logic replyReady;
  int n_errors = 0;
  int tests_run = 0;
  int nGood = 0;
  logic [31:0] cyc = 32'h0;
  logic [31:0] lastAt;
  logic [31:0] goodAt;
  logic [7:0] rxGot[$];
  logic lastGot[$];
  logic [7:0] tx[$];
  logic [7:0] exp[$];

  // Short gap keeps the run length dominated by the fixed bit rate
  serial_drive_telegram_framer #(.GAP_CYCLES(GAP)) dut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rxPin(rxPin),
    .txPin(txPin),
    .txEnable(txEnable),
    .cfg(cfg),
    .rxData(rxData),
    .rxDataValid(rxDataValid),
    .rxDataLast(rxDataLast),
    .frameGood(frameGood),
    .frameSpecial(frameSpecial),
    .params(params),
    .replyGo(replyGo),
    .replyDrop(replyDrop),
    .replyLength(replyLength),
    .replyData(replyData),
    .replyValid(replyValid),
    .replyReady(replyReady)
  );

  telegram_master_model master (
    .sys_clk(sys_clk),
    .txPin(txPin),
    .txEnable(txEnable),
    .lineOut(rxPin)
  );

  initial
  begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk)
  begin
    cyc = cyc + 32'h1;
    if (rxDataValid === 1'h1)
    begin
      rxGot.push_back(rxData);
      lastGot.push_back(rxDataLast);
    end
    if (rxDataLast === 1'h1)
      lastAt = cyc;
    if (frameGood === 1'h1)
    begin
      nGood++;
      goodAt = cyc;
    end
  end

  task automatic check1(input string what, input logic e, input logic s);
    tests_run++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : check1

  task automatic check8(input string what, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : check8

  task automatic waitLevel(input logic lvl, input int lim);
    int n;
    n = 0;
    while (txEnable !== lvl && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
    check1("wait level", lvl, txEnable);
  endtask : waitLevel

  function automatic logic [7:0] xsum(input logic [7:0] q[$]);
    logic [7:0] x;
    x = 8'h00;
    foreach (q[i]) x ^= q[i];
    return x;
  endfunction : xsum

  task automatic checkSeq;
    check8("tx count", 8'(exp.size()), 8'(master.got.size()));
    foreach (exp[i]) check8("tx byte", exp[i], master.got[i]);
    check8("bad elements", 8'h00, 8'(master.badElems));
    master.got.delete();
  endtask : checkSeq

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    // All scenarios together need about 70k cycles
    repeat (90000) @(negedge sys_clk);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    resetn = 1'h0;
    cfg = '{5'h05, 4'h1, 7'h00};
    replyGo = 1'h0;
    replyDrop = 1'h0;
    replyLength = 8'h00;
    replyData = 8'h00;
    replyValid = 1'h0;
    repeat (8) @(negedge sys_clk);
    check1("idle txPin", 1'h1, txPin);
    check1("idle txEnable", 1'h0, txEnable);
    resetn = 1'h1;
    repeat (4) @(negedge sys_clk);
    tx = {8'h02, 8'h04, 8'h05, 8'hA1, 8'hB2};
    master.send(tx);
    check8("rx count", 8'h02, 8'(rxGot.size()));
    check8("rx byte", 8'hA1, rxGot[0]);
    check8("rx byte", 8'hB2, rxGot[1]);
    check1("rx last", 1'h0, lastGot[0]);
    check1("rx last", 1'h1, lastGot[1]);
    check8("good count", 8'h01, 8'(nGood));
    check8("good delay", 8'h01, 8'(goodAt - lastAt));
    check1("special", 1'h0, frameSpecial);
    check8("params", 8'h00, params[7:0]);
    // Fill the reply queue; the ninth byte must be refused
    replyValid = 1'h1;
    for (int k = 0; k < 8; k++)
    begin
      replyData = 8'h10 + 8'(k);
      check1("queue ready", 1'h1, replyReady);
      @(negedge sys_clk);
    end
    replyData = 8'hEE;
    check1("queue full", 1'h0, replyReady);
    @(negedge sys_clk);
    replyValid = 1'h0;
    // Drop raised together with go: go must win
    replyGo = 1'h1;
    replyDrop = 1'h1;
    replyLength = 8'h08;
    @(negedge sys_clk);
    replyGo = 1'h0;
    replyDrop = 1'h0;
    exp = {8'h02, 8'h0A, 8'h05};
    for (int k = 0; k < 8; k++)
      exp.push_back(8'h10 + 8'(k));
    exp.push_back(xsum(exp));
    waitLevel(1'h1, GAP + 10);
    waitLevel(1'h0, 30000);
    repeat (BIT) @(negedge sys_clk);
    checkSeq();
    tx = {8'h02, 8'h02, 8'h06};
    master.send(tx);
    check8("good count", 8'h01, 8'(nGood));
    check8("tx count", 8'h00, 8'(master.got.size()));
    tx = {8'h02, 8'h02, 8'h45};
    master.send(tx);
    exp = tx;
    exp.push_back(xsum(tx));
    waitLevel(1'h0, 15000);
    repeat (BIT) @(negedge sys_clk);
    checkSeq();
    cfg = '{5'h05, 4'h0, 7'h03};
    rxGot.delete();
    tx = {8'h02, 8'h08, 8'h05, 8'h2C, 8'h5A, 8'h81, 8'h07, 8'h00, 8'h09};
    master.send(tx);
    check8("rx count", 8'h06, 8'(rxGot.size()));
    check8("good count", 8'h02, 8'(nGood));
    check8("job id", 8'h02, 8'(params.job_identifier));
    check8("param number hi", 8'h04, 8'(params.parameter_number[10:8]));
    check8("param number lo", 8'h5A, params.parameter_number[7:0]);
    check8("page index", 8'h81, params.pageIndex);
    check8("subindex", 8'h07, params.subIndex);
    // Reply's first channel byte is queued with the reserved bit set
    replyValid = 1'h1;
    replyData = 8'hFF;
    @(negedge sys_clk);
    replyData = 8'h34;
    @(negedge sys_clk);
    replyValid = 1'h0;
    replyGo = 1'h1;
    replyLength = 8'h02;
    @(negedge sys_clk);
    replyGo = 1'h0;
    exp = {8'h02, 8'h04, 8'h05, 8'hF7, 8'h34};
    exp.push_back(xsum(exp));
    waitLevel(1'h1, GAP + 10);
    waitLevel(1'h0, 15000);
    repeat (BIT) @(negedge sys_clk);
    checkSeq();
    report_and_stop();
  end
endmodule : serial_drive_telegram_framer_bench
